// ### rtl/ecsp_mac_end.sv
`timescale 1ns/1ps
// Contract
// - client holds valid from first to last
// - first marker flags opening beat
// - empty counts unused low bytes, last beat
// - rx valid only with new data
// - rx word held while valid low
// - last marker carries the empty count
// - transmit and receive run independently
// - tx beat only when ready same cycle
module ecsp_mac_end (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  ecsp_link_if.mac          link,
  // transmit beats toward the mac core
  output logic      [255:0] core_tx_word,
  output logic              core_tx_valid,
  output logic              core_tx_first,
  output logic              core_tx_last,
  output logic      [4:0]   core_tx_unused,
  input  wire logic         core_tx_ready,
  output logic              core_tx_framing_err,
  // received beats from the mac core
  input  wire logic [255:0] core_rx_word,
  input  wire logic         core_rx_valid,
  input  wire logic         core_rx_first,
  input  wire logic         core_rx_last,
  input  wire logic [4:0]   core_rx_unused,
  output logic              core_rx_ready
);
  typedef enum logic [1:0] {
    ECSP_PK_IDLE = 2'b01,
    ECSP_PK_BODY = 2'b10
  } ecsp_pk_e;

  localparam int unsigned EW = ecsp_pkg::ENTRY_W;
  localparam int unsigned WW = ecsp_pkg::WORD_W;
  localparam int unsigned MW = ecsp_pkg::EMPTY_W;

  ecsp_pk_e        tx_st_q;
  logic            tx_take;
  logic [EW-1:0]   tx_in;
  logic [EW-1:0]   tx_out;
  logic            tx_fifo_ready;
  logic [MW-1:0]   tx_unused_m;
  logic            tx_gap_fault;
  logic            tx_first_fault;
  logic            tx_orphan_fault;
  logic [EW-1:0]   rx_out;
  logic            rx_out_valid;
  logic            rx_pop;
  logic [WW-1:0]   rx_word_q;
  logic            rx_valid_q;
  logic            rx_first_q;
  logic            rx_last_q;
  logic [MW-1:0]   rx_unused_q;

  // ---------------- transmit: client -> fifo -> core
  // zero ready latency: the fifo space is shown combinationally
  assign link.client_tx_ready = tx_fifo_ready;
  assign tx_take = link.client_tx_beat_valid && tx_fifo_ready;
  assign tx_unused_m = link.client_tx_pkt_last ?
                       link.client_tx_unused_bytes : ecsp_pkg::EMPTY_NONE;
  assign tx_in = {link.client_tx_word, tx_unused_m,
                  link.client_tx_pkt_first, link.client_tx_pkt_last};

  // sixteen beats of slack let the core stall without dropping client beats
  ecsp_fifo #(
    .WIDTH (EW),
    .DEPTH (ecsp_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (tx_in),
    .in_valid  (link.client_tx_beat_valid),
    .in_ready  (tx_fifo_ready),
    .out_data  (tx_out),
    .out_valid (core_tx_valid),
    .out_ready (core_tx_ready)
  );

  assign core_tx_word   = tx_out[EW-1 -: WW];
  assign core_tx_unused = tx_out[MW+1 -: MW];
  assign core_tx_first  = tx_out[1];
  assign core_tx_last   = tx_out[0];

  // tracks packet framing; a gap or stray marker is flagged sticky
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_st_q <= ECSP_PK_IDLE;
    end
    else
    begin
      case (tx_st_q)
        ECSP_PK_IDLE:
        begin
          if (tx_take && link.client_tx_pkt_first && !link.client_tx_pkt_last)
          begin
            tx_st_q <= ECSP_PK_BODY;
          end
        end
        ECSP_PK_BODY:
        begin
          if (!link.client_tx_beat_valid || (tx_take && link.client_tx_pkt_last))
          begin
            tx_st_q <= ECSP_PK_IDLE;
          end
        end
        default:
        begin
          tx_st_q <= ECSP_PK_IDLE;
        end
      endcase
    end
  end

  // three ways a client can break packet framing
  always_comb
  begin
    tx_gap_fault    = 1'b0;
    tx_first_fault  = 1'b0;
    tx_orphan_fault = 1'b0;
    case (tx_st_q)
      ECSP_PK_BODY:
      begin
        // a gap is caught in the cycle valid drops, before any later beat
        tx_gap_fault   = !link.client_tx_beat_valid;
        tx_first_fault = tx_take && link.client_tx_pkt_first;
      end
      ECSP_PK_IDLE:
      begin
        tx_orphan_fault = tx_take && !link.client_tx_pkt_first;
      end
      default:
      begin
        tx_gap_fault = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_tx_framing_err <= 1'b0;
    end
    else if (tx_gap_fault || tx_first_fault || tx_orphan_fault)
    begin
      core_tx_framing_err <= 1'b1;
    end
  end

  // ---------------- receive: core -> fifo -> client, no back-pressure from client
  // core_rx_ready only falls if the core outruns one beat per cycle
  ecsp_fifo #(
    .WIDTH (EW),
    .DEPTH (ecsp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   ({core_rx_word, core_rx_unused, core_rx_first, core_rx_last}),
    .in_valid  (core_rx_valid),
    .in_ready  (core_rx_ready),
    .out_data  (rx_out),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop)
  );

  // the client has no ready, so every queued beat drains one per cycle
  assign rx_pop = rx_out_valid;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rx_pop;
    end
  end

  // word, markers and count only load with a new beat, else they hold
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_word_q   <= ecsp_pkg::WORD_ZERO;
      rx_first_q  <= 1'b0;
      rx_last_q   <= 1'b0;
      rx_unused_q <= ecsp_pkg::EMPTY_NONE;
    end
    else if (rx_pop)
    begin
      rx_word_q   <= rx_out[EW-1 -: WW];
      rx_first_q  <= rx_out[1];
      rx_last_q   <= rx_out[0];
      rx_unused_q <= rx_out[0] ? rx_out[MW+1 -: MW] : ecsp_pkg::EMPTY_NONE;
    end
  end

  assign link.client_rx_word         = rx_word_q;
  assign link.client_rx_beat_valid   = rx_valid_q;
  assign link.client_rx_pkt_first    = rx_valid_q && rx_first_q;
  assign link.client_rx_pkt_last     = rx_valid_q && rx_last_q;
  assign link.client_rx_unused_bytes = rx_unused_q;
endmodule

// ### rtl/ecsp_pkg.sv
package ecsp_pkg;
  localparam int unsigned WORD_W      = 256;
  localparam int unsigned EMPTY_W     = 5;
  localparam int unsigned FIFO_DEPTH  = 16;
  // fifo entry: word, unused count, first, last
  localparam int unsigned ENTRY_W     = WORD_W + EMPTY_W + 2;
  localparam logic [EMPTY_W-1:0] EMPTY_NONE = 5'h0_0;
  localparam logic [WORD_W-1:0]  WORD_ZERO  = '0;
endpackage

// ### rtl/ecsp_link_if.sv
`timescale 1ns/1ps
interface ecsp_link_if;
  logic [255:0] client_tx_word;
  logic         client_tx_beat_valid;
  logic         client_tx_ready;
  logic         client_tx_pkt_first;
  logic         client_tx_pkt_last;
  logic [4:0]   client_tx_unused_bytes;
  logic [255:0] client_rx_word;
  logic         client_rx_beat_valid;
  logic         client_rx_pkt_first;
  logic         client_rx_pkt_last;
  logic [4:0]   client_rx_unused_bytes;

  modport mac
  (
    input  client_tx_word, client_tx_beat_valid, client_tx_pkt_first,
    input  client_tx_pkt_last, client_tx_unused_bytes,
    output client_tx_ready,
    output client_rx_word, client_rx_beat_valid, client_rx_pkt_first,
    output client_rx_pkt_last, client_rx_unused_bytes
  );

  modport client
  (
    output client_tx_word, client_tx_beat_valid, client_tx_pkt_first,
    output client_tx_pkt_last, client_tx_unused_bytes,
    input  client_tx_ready,
    input  client_rx_word, client_rx_beat_valid, client_rx_pkt_first,
    input  client_rx_pkt_last, client_rx_unused_bytes
  );
endinterface

// ### rtl/ecsp_fifo.sv
`timescale 1ns/1ps
module ecsp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### rtl/ecsp_client_end.sv
`timescale 1ns/1ps
module ecsp_client_end (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  ecsp_link_if.client       link,
  // user transmit side: one beat per cycle, taken when usr_tx_ready
  input  wire logic [255:0] usr_tx_word,
  input  wire logic         usr_tx_valid,
  input  wire logic         usr_tx_first,
  input  wire logic         usr_tx_last,
  input  wire logic [4:0]   usr_tx_unused,
  output logic              usr_tx_ready,
  // user receive side: copies of accepted beats
  output logic      [255:0] usr_rx_word,
  output logic              usr_rx_valid,
  output logic              usr_rx_first,
  output logic              usr_rx_last,
  output logic      [4:0]   usr_rx_unused
);
  // beats only ever pass while the mac is ready in the same cycle
  assign usr_tx_ready = link.client_tx_ready;

  // valid held through the packet; the user must not gap a packet
  assign link.client_tx_beat_valid = usr_tx_valid;
  assign link.client_tx_word       = usr_tx_word;
  assign link.client_tx_pkt_first  = usr_tx_valid && usr_tx_first;
  assign link.client_tx_pkt_last   = usr_tx_valid && usr_tx_last;
  assign link.client_tx_unused_bytes =
    (usr_tx_valid && usr_tx_last) ? usr_tx_unused : ecsp_pkg::EMPTY_NONE;

  // receive runs independently of transmit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      usr_rx_valid  <= 1'b0;
      usr_rx_first  <= 1'b0;
      usr_rx_last   <= 1'b0;
      usr_rx_unused <= ecsp_pkg::EMPTY_NONE;
      usr_rx_word   <= ecsp_pkg::WORD_ZERO;
    end
    else
    begin
      usr_rx_valid <= link.client_rx_beat_valid;
      if (link.client_rx_beat_valid)
      begin
        usr_rx_word   <= link.client_rx_word;
        usr_rx_first  <= link.client_rx_pkt_first;
        usr_rx_last   <= link.client_rx_pkt_last;
        usr_rx_unused <= link.client_rx_pkt_last ?
                         link.client_rx_unused_bytes : ecsp_pkg::EMPTY_NONE;
      end
    end
  end
endmodule

// ### test/ecsp_link_monitor.sv
`timescale 1ns/1ps
module ecsp_link_monitor (
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic [255:0] client_tx_word,
  input wire logic         client_tx_beat_valid,
  input wire logic         client_tx_ready,
  input wire logic         client_tx_pkt_first,
  input wire logic         client_tx_pkt_last,
  input wire logic [4:0]   client_tx_unused_bytes,
  input wire logic [255:0] client_rx_word,
  input wire logic         client_rx_beat_valid,
  input wire logic         client_rx_pkt_first,
  input wire logic         client_rx_pkt_last,
  input wire logic [4:0]   client_rx_unused_bytes
);
  logic tx_open_q;
  logic rx_open_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tx_open_q <= 1'b0;
    else if (client_tx_beat_valid && client_tx_ready)
      tx_open_q <= !client_tx_pkt_last;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rx_open_q <= 1'b0;
    else if (client_rx_beat_valid)
      rx_open_q <= !client_rx_pkt_last;
  end
  a_rx_word_held: assert property (!client_rx_beat_valid |-> $stable(client_rx_word))
    else $error("rx word moved without valid");
  a_rx_word_new: assert property (!$stable(client_rx_word) |-> client_rx_beat_valid)
    else $error("rx word changed outside a beat");
  a_rx_first_opens: assert property (client_rx_beat_valid && !rx_open_q
    |-> client_rx_pkt_first)
    else $error("rx packet opened without first");
  a_rx_first_inside: assert property (client_rx_beat_valid && rx_open_q
    |-> !client_rx_pkt_first)
    else $error("rx first inside a packet");
  a_rx_last_valid: assert property (client_rx_pkt_last |-> client_rx_beat_valid)
    else $error("rx last without valid");
  a_rx_empty_idle: assert property (client_rx_beat_valid && !client_rx_pkt_last
    |-> client_rx_unused_bytes == 5'h0_0)
    else $error("rx unused count on a non-last beat");
  a_tx_empty_forced: assert property (client_tx_beat_valid && !client_tx_pkt_last
    |-> client_tx_unused_bytes == 5'h0_0)
    else $error("tx unused count on a non-last beat");
  a_tx_beat_held: assert property (client_tx_beat_valid && !client_tx_ready
    |=> client_tx_beat_valid && $stable(client_tx_word))
    else $error("tx beat dropped while not ready");
  c_tx_stall: cover property (client_tx_beat_valid && !client_tx_ready);
  c_rx_gap: cover property (client_rx_beat_valid ##1 !client_rx_beat_valid ##1 client_rx_beat_valid);
  c_both: cover property (client_rx_beat_valid && client_tx_beat_valid && client_tx_ready);
endmodule

// ### test/eth40_client_stream_port_test.sv
`timescale 1ns/1ps
module eth40_client_stream_port_test;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [255:0] usr_tx_word = '0, core_rx_word = '0, usr_rx_word, core_tx_word;
  logic usr_tx_valid = 1'b0, usr_tx_first = 1'b0, usr_tx_last = 1'b0, usr_tx_ready;
  logic core_rx_valid = 1'b0, core_rx_first = 1'b0, core_rx_last = 1'b0, core_rx_ready;
  logic [4:0] usr_tx_unused = '0, core_rx_unused = '0, usr_rx_unused, core_tx_unused;
  logic usr_rx_valid, usr_rx_first, usr_rx_last, core_tx_framing_err;
  logic core_tx_valid, core_tx_first, core_tx_last, core_tx_ready = 1'b1;
  int mismatches = 0, check_count = 0;
  logic [262:0] txq[$], rxq[$], last_rx;
  ecsp_link_if link ();
  ecsp_client_end ecsp_client_end_i (.clk, .sys_rst, .link(link.client), .usr_tx_word,
    .usr_tx_valid, .usr_tx_first, .usr_tx_last, .usr_tx_unused, .usr_tx_ready,
    .usr_rx_word, .usr_rx_valid, .usr_rx_first, .usr_rx_last, .usr_rx_unused);
  ecsp_mac_end ecsp_mac_end_i (.clk, .sys_rst, .link(link.mac), .core_tx_word, .core_tx_valid,
    .core_tx_first, .core_tx_last, .core_tx_unused, .core_tx_ready, .core_tx_framing_err,
    .core_rx_word, .core_rx_valid, .core_rx_first, .core_rx_last, .core_rx_unused,
    .core_rx_ready);
  ecsp_link_monitor ecsp_link_monitor_i (.clk(clk), .sys_rst(sys_rst),
    .client_tx_word(link.client_tx_word), .client_tx_beat_valid(link.client_tx_beat_valid),
    .client_tx_ready(link.client_tx_ready), .client_tx_pkt_first(link.client_tx_pkt_first),
    .client_tx_pkt_last(link.client_tx_pkt_last),
    .client_tx_unused_bytes(link.client_tx_unused_bytes),
    .client_rx_word(link.client_rx_word), .client_rx_beat_valid(link.client_rx_beat_valid),
    .client_rx_pkt_first(link.client_rx_pkt_first), .client_rx_pkt_last(link.client_rx_pkt_last),
    .client_rx_unused_bytes(link.client_rx_unused_bytes));
  task automatic check(input logic [262:0] seen, input logic [262:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // non-last beats expect unused forced to zero
  task automatic tx_beat(input logic [255:0] w, input logic f, l, input logic [4:0] u);
    int n;
    n = 0;
    usr_tx_valid <= 1'b1;
    usr_tx_word <= w;
    usr_tx_first <= f;
    usr_tx_last <= l;
    usr_tx_unused <= u;
    txq.push_back({w, l ? u : 5'h0_0, f, l});
    do @(posedge clk); while (!usr_tx_ready && ++n < 200);
  endtask
  task automatic rx_beat(input logic [255:0] w, input logic f, l, input logic [4:0] u);
    int n;
    n = 0;
    core_rx_valid <= 1'b1;
    core_rx_word <= w;
    core_rx_first <= f;
    core_rx_last <= l;
    core_rx_unused <= u;
    rxq.push_back({w, l ? u : 5'h0_0, f, l});
    do @(posedge clk); while (!core_rx_ready && ++n < 200);
  endtask
  task automatic tx_gap(input int n);
    usr_tx_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rx_gap(input int n);
    core_rx_valid <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // usr copy lags the link by one edge, so compare before updating last_rx
  always @(posedge clk)
  begin
    if (core_tx_valid && core_tx_ready)
      check({core_tx_word, core_tx_unused, core_tx_first, core_tx_last}, txq.pop_front());
    if (usr_rx_valid)
      check({usr_rx_word, usr_rx_unused, usr_rx_first, usr_rx_last}, last_rx);
    if (link.client_rx_beat_valid)
    begin
      last_rx = {link.client_rx_word, link.client_rx_unused_bytes, link.client_rx_pkt_first,
        link.client_rx_pkt_last};
      check(last_rx, rxq.pop_front());
    end
  end
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #80_000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(usr_tx_ready, 1'b1);
    check(link.client_rx_beat_valid, 1'b0);
    check(core_rx_ready, 1'b1);
    fork
      begin
        tx_beat(256'hA5A5_0001, 1'b1, 1'b0, 5'h1_F);
        tx_beat(256'hA5A5_0002, 1'b0, 1'b0, 5'h0_0);
        tx_beat(256'hA5A5_0003, 1'b0, 1'b1, 5'h0_2);
        tx_beat(256'hA5A5_0004, 1'b1, 1'b1, 5'h1_F);
        tx_gap(1);
      end
      begin
        rx_beat(256'h5A5A_0001, 1'b1, 1'b0, 5'h0_9);
        rx_gap(2);
        rx_beat(256'h5A5A_0002, 1'b0, 1'b0, 5'h0_0);
        rx_gap(1);
        rx_beat(256'h5A5A_0003, 1'b0, 1'b1, 5'h1_D);
        rx_beat(256'h5A5A_0004, 1'b1, 1'b1, 5'h0_7);
        rx_gap(4);
      end
    join
    check(rxq.size(), 0);
    // stall the core until the fifo refuses
    core_tx_ready <= 1'b0;
    for (int i = 0; i < 16; i++)
      tx_beat(256'(i), i == 0, i == 15, 5'h0_3);
    tx_gap(1);
    check(usr_tx_ready, 1'b0);
    fork
      tx_beat(256'hBEEF, 1'b1, 1'b1, 5'h0_1);
      begin
        repeat (5) @(posedge clk);
        core_tx_ready <= 1'b1;
      end
    join
    tx_gap(40);
    check(core_tx_valid, 1'b0);
    check(txq.size(), 0);
    check(core_tx_framing_err, 1'b0);
    tx_beat(256'hC0DE_0001, 1'b1, 1'b0, 5'h0_0);
    tx_gap(1);
    tx_beat(256'hC0DE_0002, 1'b0, 1'b1, 5'h0_4);
    tx_gap(3);
    check(core_tx_framing_err, 1'b1);
    wrap_up();
  end
endmodule
